// File: logic/icc_ctrl.sv
// instruction cache control: command decode, lock, status and set store
`timescale 1ns/1ps
// Contract
// R1 - opcode 0..6 selects the cache operation
// R2 - load-lock: address from op2, ways from op3
// R3 - status ops write word; bit0 enable
// R4 - store sets: op2 address, op3 set selection
// R5 - status 7:4 reads log2 bytes per atom
// R6 - status 11:8 reads log2 atoms per line
// R7 - status 15:12 reads log2 set count; code reads 8 though NUM_SETS is 128
// R8 - status 27:16 reads ways minus one
// R9 - lock 7:0 reads lockable block count
// R10 - lock 23:8 reads block size 1024
// R11 - lock 31:24 reads locked block count
// R12 - system command type in bits 15:8
// R13 - type 1 invalidates whole cache
// R14 - type 2 configures mode, op2 load address
// R15 - unused operands and fields ignored
// R16 - software keeps reserved operand bits clear
// R17 - legacy lock fills exactly one way
// R18 - locked ways refuse replacement updates
// R19 - no snooping of program memory writes
// R20 - store writes data, tag, valid words
// R21 - operation completes before later fetches
module icc_ctrl (
    input  wire logic        clk_sys,        // system clock
    input  wire logic        sys_rst,        // synchronous reset, high
    input  wire logic [4:0]  avs_address,    // byte address
    input  wire logic        avs_read,       // read strobe
    input  wire logic        avs_write,      // write strobe
    input  wire logic [31:0] avs_writedata,  // write data
    input  wire logic [3:0]  avs_byteenable, // byte enables
    output logic [31:0]      avs_readdata,   // read data
    output logic             avs_waitrequest,// stall
    output logic             mem_req,        // memory request
    output logic             mem_we,         // memory write
    output logic [31:0]      mem_addr,       // memory byte address
    output logic [31:0]      mem_wdata,      // memory write data
    input  wire logic        mem_ack,        // memory done
    input  wire logic [31:0] mem_rdata,      // memory read data
    input  wire logic        fetch_req,      // fetch lookup request
    output logic             fetch_stall,    // fetch must wait
    output logic             cache_enabled,  // cache enable level
    output logic [3:0]       locked_ways     // ways locked
);
    typedef struct packed {
        icc_pkg::icc_state_e st;
        logic [31:0] op2;
        logic [31:0] op3;
        logic [31:0] result;
        logic        en;
        logic [3:0]  lock;
        logic [3:0]  valid;
        logic [2:0]  nlock;
        logic [1:0]  way;
        logic [2:0]  ways_left;
        logic [9:0]  word;
        logic [7:0]  sets;
        logic [6:0]  set;
        logic [3:0]  phase;
        logic [31:0] maddr;
        logic        req;
        logic        we;
        logic [31:0] wdata;
        logic        ack_bus;
        logic [31:0] rdata;
        logic [11:0] lookup;
    } icc_state_s;

    icc_state_s s_reg;
    icc_state_s s_next;
    icc_mem_if  mif ();

    icc_way_mem u_mem (
        .clk_sys (clk_sys),
        .port    (mif.mem)
    );

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction : merge

    function automatic logic [2:0] count4(input logic [3:0] v);
        return {2'b00, v[0]} + {2'b00, v[1]} + {2'b00, v[2]}
             + {2'b00, v[3]};
    endfunction : count4

    logic        busy;
    logic        wr_hit;
    logic [31:0] cmd;
    assign busy   = (s_reg.st != icc_pkg::ICC_IDLE);
    assign wr_hit = avs_write && !s_reg.ack_bus;
    assign cmd    = avs_writedata;

    // memory port: fill writes during load, reads during store or lookup
    assign mif.we    = (s_reg.st == icc_pkg::ICC_FILL) && s_reg.req
                       && mem_ack && !s_reg.lock[s_reg.way];
    assign mif.waddr = {s_reg.way, s_reg.word};
    assign mif.wdata = mem_rdata;
    // address follows the next state so the registered word is fresh
    assign mif.raddr = (s_next.st == icc_pkg::ICC_STORE)
                       ? {s_next.phase[3:2], s_next.set, s_next.phase[1:0],
                          1'b0} : s_reg.lookup;

    always_comb begin
        s_next         = s_reg;
        s_next.ack_bus = 1'b0;
        s_next.nlock   = count4(s_reg.lock);
        unique case (s_reg.st)
            icc_pkg::ICC_IDLE: begin
                if (avs_read && !s_reg.ack_bus) begin
                    s_next.ack_bus = 1'b1;
                    unique case (avs_address)
                        icc_pkg::A_OP2:      s_next.rdata = s_reg.op2;
                        icc_pkg::A_OP3:      s_next.rdata = s_reg.op3;
                        icc_pkg::A_RESULT:   s_next.rdata = s_reg.result;
                        icc_pkg::A_STATE:    s_next.rdata =
                            {23'h0, s_reg.nlock, s_reg.lock, 1'b0,
                             s_reg.en};
                        icc_pkg::A_LOOKDATA: s_next.rdata = mif.rdata;
                        default:             s_next.rdata = 32'h0;
                    endcase
                end else if (wr_hit) begin
                    s_next.ack_bus = 1'b1;
                    unique case (avs_address)
                        icc_pkg::A_OP2:
                            s_next.op2 = merge(s_reg.op2, cmd,
                                               avs_byteenable);
                        icc_pkg::A_OP3:
                            s_next.op3 = merge(s_reg.op3, cmd,
                                               avs_byteenable);
                        icc_pkg::A_LOOKUP: s_next.lookup = cmd[11:0];
                        icc_pkg::A_CMD: begin
                            if (!cmd[icc_pkg::CMD_KIND_BIT]) begin
                                // R1 opcode decode
                                unique case (cmd[3:0])
                                    icc_pkg::OP_DISABLE: s_next.en = 1'b0;
                                    icc_pkg::OP_ENABLE:  s_next.en = 1'b1;
                                    icc_pkg::OP_INVALIDATE:
                                        s_next.st = icc_pkg::ICC_INV;
                                    icc_pkg::OP_LOAD_LOCK: begin
                                        // R2 address and way count
                                        s_next.maddr = s_reg.op2;
                                        s_next.ways_left =
                                            (s_reg.op3 > 32'd4) ? 3'd4
                                            : s_reg.op3[2:0];
                                        s_next.way  = 2'd0;
                                        s_next.word = 10'd0;
                                        s_next.req  = 1'b0;
                                        s_next.st   = icc_pkg::ICC_FILL;
                                    end
                                    icc_pkg::OP_STATUS: begin
                                        // R3 R5 R6 R7 R8 status word
                                        s_next.result =
                                            {4'h0, icc_pkg::ST_WAYS_M1,
                                             icc_pkg::ST_LOG_SETS,
                                             icc_pkg::ST_LOG_APL,
                                             icc_pkg::ST_LOG_BPA,
                                             3'b000, s_reg.en};
                                    end
                                    icc_pkg::OP_LOCK_STAT: begin
                                        // R9 R10 R11 lock status word
                                        s_next.result =
                                            {5'h0, s_reg.nlock,
                                             icc_pkg::LK_BLK_WORDS,
                                             icc_pkg::LK_BLOCKS};
                                    end
                                    icc_pkg::OP_STORE_SETS: begin
                                        // R4 destination and set mask
                                        s_next.maddr = s_reg.op2;
                                        s_next.sets  = s_reg.op3[7:0];
                                        s_next.set   = 7'd0;
                                        s_next.phase = 4'd0;
                                        s_next.req   = 1'b0;
                                        s_next.st    = icc_pkg::ICC_STORE;
                                    end
                                    default: ;
                                endcase
                            end else begin
                                // R12 R15 message type, others ignored
                                unique case (cmd[icc_pkg::MSG_MSB:
                                                 icc_pkg::MSG_LSB])
                                    // R13 whole-cache invalidate
                                    icc_pkg::MSG_INVALIDATE:
                                        s_next.st = icc_pkg::ICC_INV;
                                    icc_pkg::MSG_CONFIGURE: begin
                                        // R14 mode byte and load address
                                        s_next.en =
                                            cmd[icc_pkg::MODE_EN_BIT];
                                        if (cmd[icc_pkg::MODE_LOCK_BIT])
                                        begin
                                            // R17 single way only
                                            s_next.maddr = s_reg.op2;
                                            s_next.ways_left = 3'd1;
                                            s_next.way  = 2'd0;
                                            s_next.word = 10'd0;
                                            s_next.req  = 1'b0;
                                            s_next.st = icc_pkg::ICC_FILL;
                                        end
                                    end
                                    default: ;
                                endcase
                            end
                        end
                        default: ;
                    endcase
                end
            end
            icc_pkg::ICC_INV: begin
                // invalidate drops contents and locks
                s_next.valid = 4'h0;
                s_next.lock  = 4'h0;
                s_next.st    = icc_pkg::ICC_DONE;
            end
            icc_pkg::ICC_FILL: begin
                if (s_reg.ways_left == 3'd0) begin
                    s_next.st = icc_pkg::ICC_DONE;
                end else if (!s_reg.req) begin
                    s_next.req  = 1'b1;
                    s_next.we   = 1'b0;
                end else if (mem_ack) begin
                    s_next.req   = 1'b0;
                    s_next.maddr = s_reg.maddr + 32'd4;
                    s_next.word  = s_reg.word + 10'd1;
                    if (s_reg.word == 10'h3ff) begin
                        // R18 filled way becomes locked
                        s_next.lock[s_reg.way]  = 1'b1;
                        s_next.valid[s_reg.way] = 1'b1;
                        s_next.way       = s_reg.way + 2'd1;
                        s_next.ways_left = s_reg.ways_left - 3'd1;
                    end
                end
            end
            icc_pkg::ICC_STORE: begin
                // R20 data, tag and valid words per selected set
                if (s_reg.sets == 8'h0 && !s_reg.req) begin
                    s_next.st = icc_pkg::ICC_DONE;
                end else if (!s_reg.req) begin
                    if (s_reg.sets[0]) begin
                        s_next.req   = 1'b1;
                        s_next.we    = 1'b1;
                        s_next.wdata = (s_reg.phase < 4'd8) ? mif.rdata
                                     : {25'h0, s_reg.set};
                        if (s_reg.phase == 4'd9) begin
                            s_next.wdata = {28'h0, s_reg.valid};
                        end
                    end else begin
                        // unselected set: skip without a memory cycle
                        s_next.sets = {1'b0, s_reg.sets[7:1]};
                        s_next.set  = s_reg.set + 7'd1;
                    end
                end else if (mem_ack) begin
                    s_next.req   = 1'b0;
                    s_next.maddr = s_reg.maddr + 32'd4;
                    s_next.phase = s_reg.phase + 4'd1;
                    if (s_reg.phase == 4'd9) begin
                        s_next.phase = 4'd0;
                        s_next.sets  = {1'b0, s_reg.sets[7:1]};
                        s_next.set   = s_reg.set + 7'd1;
                    end
                end
            end
            icc_pkg::ICC_DONE: begin
                s_next.req = 1'b0;
                s_next.st  = icc_pkg::ICC_IDLE;
            end
            default: s_next.st = icc_pkg::ICC_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_reg         <= '0;
            s_reg.st      <= icc_pkg::ICC_IDLE;
        end else begin
            s_reg <= s_next;
        end
    end

    // R21 fetches wait until the operation completes
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            fetch_stall <= 1'b0;
        end else begin
            fetch_stall <= fetch_req && (s_next.st != icc_pkg::ICC_IDLE);
        end
    end

    // R19 no snoop input exists: memory writes never touch the arrays
    assign avs_readdata    = s_reg.rdata;
    assign avs_waitrequest = !s_reg.ack_bus;
    assign mem_req         = s_reg.req;
    assign mem_we          = s_reg.we;
    assign mem_addr        = s_reg.maddr;
    assign mem_wdata       = s_reg.wdata;
    assign cache_enabled   = s_reg.en;
    assign locked_ways     = s_reg.lock;
endmodule : icc_ctrl

// File: logic/icc_mem_if.sv
// interface: port bundle between the control and the way data memory
`timescale 1ns/1ps
interface icc_mem_if;
    logic        we;
    logic [11:0] waddr;
    logic [31:0] wdata;
    logic [11:0] raddr;
    logic [31:0] rdata;
    modport ctrl (output we, output waddr, output wdata, output raddr,
                  input rdata);
    modport mem  (input we, input waddr, input wdata, input raddr,
                  output rdata);
endinterface : icc_mem_if

// File: logic/icc_pkg.sv
// package: constants and types for the instruction cache control block
package icc_pkg;
    // cache-control operation codes
    localparam logic [3:0] OP_DISABLE    = 4'h0;
    localparam logic [3:0] OP_ENABLE     = 4'h1;
    localparam logic [3:0] OP_INVALIDATE = 4'h2;
    localparam logic [3:0] OP_LOAD_LOCK  = 4'h3;
    localparam logic [3:0] OP_STATUS     = 4'h4;
    localparam logic [3:0] OP_LOCK_STAT  = 4'h5;
    localparam logic [3:0] OP_STORE_SETS = 4'h6;
    // system-control message types
    localparam logic [7:0] MSG_INVALIDATE = 8'h01;
    localparam logic [7:0] MSG_CONFIGURE  = 8'h02;
    localparam int MSG_LSB    = 8;
    localparam int MSG_MSB    = 15;
    localparam int FIELD1_MSB = 7;
    // mode byte: bit 0 enables, bit 1 requests load-and-lock of one way
    localparam int MODE_EN_BIT   = 0;
    localparam int MODE_LOCK_BIT = 1;
    // organisation
    localparam int NUM_WAYS      = 4;
    localparam int NUM_SETS      = 128;
    localparam int SET_BITS      = 7;
    localparam int WORDS_PER_WAY = 1024;
    localparam int WORD_BITS     = 10;
    localparam int WORDS_PER_LINE = 8;
    localparam int LINE_BITS      = 3;
    // status field values
    localparam logic [3:0]  ST_LOG_BPA  = 4'h2;
    localparam logic [3:0]  ST_LOG_APL  = 4'h3;
    localparam logic [3:0]  ST_LOG_SETS = 4'h8;
    localparam logic [11:0] ST_WAYS_M1  = 12'h003;
    localparam logic [7:0]  LK_BLOCKS   = 8'h04;
    localparam logic [15:0] LK_BLK_WORDS = 16'h0400;
    // avalon register map (byte addresses)
    localparam logic [4:0] A_CMD      = 5'h00;
    localparam logic [4:0] A_OP2      = 5'h04;
    localparam logic [4:0] A_OP3      = 5'h08;
    localparam logic [4:0] A_RESULT   = 5'h0c;
    localparam logic [4:0] A_STATE    = 5'h10;
    localparam logic [4:0] A_LOOKUP   = 5'h14;
    localparam logic [4:0] A_LOOKDATA = 5'h18;
    // command register fields
    localparam int CMD_KIND_BIT = 31;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    typedef enum logic [2:0] {
        ICC_IDLE  = 3'b000,
        ICC_INV   = 3'b001,
        ICC_FILL  = 3'b010,
        ICC_STORE = 3'b011,
        ICC_DONE  = 3'b100
    } icc_state_e;
endpackage : icc_pkg

// File: logic/icc_way_mem.sv
// way data memory: 4 ways x 1024 words, registered read data
`timescale 1ns/1ps
module icc_way_mem (
    input  wire logic clk_sys,  // system clock
    icc_mem_if.mem    port      // write and read port
);
    logic [31:0] store_mem [0:4095];
    logic [31:0] rdata_reg;
    always_ff @(posedge clk_sys) begin
        if (port.we) begin
            store_mem[port.waddr] <= port.wdata;
        end
        rdata_reg <= store_mem[port.raddr];
    end
    assign port.rdata = rdata_reg;
endmodule : icc_way_mem

// File: test/icc_ctrl_checker.sv
// checker: bus, memory and state relations of icc_ctrl
`timescale 1ns/1ps
module icc_ctrl_checker (
    input wire logic        clk_sys,         // clock
    input wire logic        sys_rst,         // reset
    input wire logic [4:0]  avs_address,     // address
    input wire logic        avs_read,        // read
    input wire logic        avs_write,       // write
    input wire logic [31:0] avs_writedata,   // write data
    input wire logic [31:0] avs_readdata,    // read data
    input wire logic        avs_waitrequest, // stall
    input wire logic        mem_req,         // mem request
    input wire logic        mem_we,          // mem write
    input wire logic [31:0] mem_addr,        // mem address
    input wire logic        mem_ack,         // mem done
    input wire logic        fetch_req,       // fetch request
    input wire logic        fetch_stall,     // busy
    input wire logic        cache_enabled,   // enable level
    input wire logic [3:0]  locked_ways      // locks
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (sys_rst);
    sequence s_op(op);
        avs_write && !avs_waitrequest && avs_address == icc_pkg::A_CMD
        && !avs_writedata[31] && avs_writedata[3:0] == op;
    endsequence
    sequence s_inv;
        avs_write && !avs_waitrequest && avs_address == icc_pkg::A_CMD
        && avs_writedata[31] && avs_writedata[15:8] == 8'h01;
    endsequence
    sequence s_rd(a);
        avs_read && !avs_waitrequest && avs_address == a;
    endsequence
    a_op_enable: assert property (
        s_op(icc_pkg::OP_ENABLE) |-> ##[1:8] cache_enabled)
        else $error("enable op left cache disabled");
    a_op_disable: assert property (
        s_op(icc_pkg::OP_DISABLE) |-> ##[1:8] !cache_enabled)
        else $error("disable op left cache enabled");
    a_inv_unlock: assert property (
        s_inv |-> ##[1:1000] locked_ways == 4'h0)
        else $error("system invalidate kept locks");
    a_state_en: assert property (
        s_rd(icc_pkg::A_STATE) |-> avs_readdata[0] == cache_enabled)
        else $error("state enable bit differs from level");
    a_state_lock: assert property (
        s_rd(icc_pkg::A_STATE) |-> avs_readdata[5:2] == locked_ways)
        else $error("state lock mask differs");
    a_state_count: assert property (
        s_rd(icc_pkg::A_STATE)
        |-> avs_readdata[8:6] == $countones(locked_ways))
        else $error("state lock count differs");
    a_unmapped_zero: assert property (
        avs_read && !avs_waitrequest && avs_address > 5'h18
        |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_req_hold: assert property (
        mem_req && !mem_ack
        |=> mem_req && $stable(mem_addr) && $stable(mem_we))
        else $error("memory request changed before ack");
    a_stall_busy: assert property (
        mem_req && $past(fetch_req) |-> fetch_stall)
        else $error("fetch not stalled during transfer");
endmodule : icc_ctrl_checker
bind icc_ctrl icc_ctrl_checker i_icc_ctrl_checker (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_ack(mem_ack),
    .fetch_req(fetch_req), .fetch_stall(fetch_stall),
    .cache_enabled(cache_enabled),
    .locked_ways(locked_ways));

// File: test/icc_ctrl_test.sv
// testbench: icc_ctrl against a reference of the cache control rules
`timescale 1ns/1ps
module icc_ctrl_test;
    logic        clk_sys = 1'b0;
    logic        sys_rst = 1'b1;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest, mem_req, mem_we, mem_ack;
    logic [31:0] mem_addr, mem_rdata, mem_wdata, exp_addr, rd;
    int          tag_q[$];
    logic        fetch_req = 1'b0;
    logic        fetch_stall, cache_enabled, exp_we;
    logic [3:0]  locked_ways;
    logic [1:0]  lat = 2'h0;
    logic [31:0] rs = 32'h55, rs2 = 32'h55;
    int          failures = 0, checked = 0, mon_cnt, en = 0, nlock = 0;
    always #10 clk_sys = ~clk_sys;
    icc_ctrl i_icc_ctrl (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .mem_req(mem_req),
        .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata),
        .fetch_req(fetch_req), .fetch_stall(fetch_stall),
        .cache_enabled(cache_enabled), .locked_ways(locked_ways));
    icc_mem_model i_icc_mem_model (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
        .lat(lat), .mem_ack(mem_ack), .mem_rdata(mem_rdata));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    task check_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check_word
    task give_verdict;
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : give_verdict
    // hold the request until waitrequest is sampled low; the watchdog
    // ends a wait that never finishes
    task bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= !w;
        avs_write <= w;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) begin
            @(posedge clk_sys);
        end
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask : bus
    // random fetch traffic and memory latency
    always @(posedge clk_sys) begin
        rs2 = xs(rs2);
        fetch_req <= rs2[0];
        lat <= rs2[2:1];
    end
    always @(posedge clk_sys) begin
        if (mem_req === 1'b1 && mem_ack === 1'b1) begin
            check_word(mem_addr, exp_addr);
            check_word({31'h0, mem_we}, {31'h0, exp_we});
            if (exp_we && mon_cnt % 10 == 8 && tag_q.size() > 0)
                check_word(mem_wdata, 32'(tag_q.pop_front()));
            if (exp_we && mon_cnt % 10 == 9)
                check_word(mem_wdata, (32'h1 << nlock) - 32'h1);
            exp_addr = exp_addr + 32'h4;
            mon_cnt++;
        end
    end
    task check_state;
        logic [31:0] st;
        st = (32'd3 << 16) | (32'd8 << 12) | (32'd3 << 8) | (32'd2 << 4);
        bus(1'b1, icc_pkg::A_CMD, {28'h0, icc_pkg::OP_STATUS});
        bus(1'b0, icc_pkg::A_RESULT, 32'h0);
        check_word(rd & 32'h0fff_ffff, st | 32'(en));
        bus(1'b1, icc_pkg::A_CMD, {28'h0, icc_pkg::OP_LOCK_STAT});
        bus(1'b0, icc_pkg::A_RESULT, 32'h0);
        st = (32'(nlock) << 24) | (32'd1024 << 8);
        check_word(rd, st | 32'(icc_pkg::LK_BLOCKS));
        bus(1'b0, icc_pkg::A_STATE, 32'h0);
        check_word(rd & 32'h1c1, (32'(nlock) << 6) | 32'(en));
        check_word({31'h0, cache_enabled}, 32'(en));
    endtask : check_state
    // unused operands are random; state read waits for the op to end
    task xfer(input logic [31:0] cmd, input logic [31:0] a3,
              input int n, input logic w);
        rs = xs(rs);
        exp_addr = {4'h0, rs[27:2], 2'b00};
        exp_we = w;
        mon_cnt = 0;
        bus(1'b1, icc_pkg::A_OP2, exp_addr);
        bus(1'b1, icc_pkg::A_OP3, a3);
        bus(1'b1, icc_pkg::A_CMD, cmd);
        bus(1'b0, icc_pkg::A_STATE, 32'h0);
        check_word(32'(mon_cnt), 32'(n));
    endtask : xfer
    initial begin
        repeat (16) @(posedge clk_sys);
        sys_rst <= 1'b0;
        @(posedge clk_sys);
        check_state;
        en = 1;
        xfer({28'h0, icc_pkg::OP_ENABLE}, xs(rs), 0, 1'b0);
        check_state;
        en = 0;
        xfer({28'h0, icc_pkg::OP_DISABLE}, xs(rs), 0, 1'b0);
        check_state;
        nlock = 4;
        xfer({28'h0, icc_pkg::OP_LOAD_LOCK}, 32'h4, 4096, 1'b0);
        check_state;
        // sets 0 and 2 selected, upper bits ignored
        tag_q = '{0, 2};
        xfer({28'h0, icc_pkg::OP_STORE_SETS}, {xs(rs) & 32'hffff_ff00}
             | 32'h05, 20, 1'b1);
        nlock = 0;
        xfer({28'h0, icc_pkg::OP_INVALIDATE}, xs(rs), 0, 1'b0);
        check_state;
        // kind, type and field bits decoded; bits 30:16 random
        en = 1;
        nlock = 1;
        xfer({1'b1, rs[14:0], icc_pkg::MSG_CONFIGURE, 8'h03}, 32'h3,
             1024, 1'b0);
        check_state;
        nlock = 0;
        xfer({1'b1, rs[30:16], icc_pkg::MSG_INVALIDATE, rs[7:0]}, xs(rs),
             0, 1'b0);
        check_state;
        bus(1'b0, 5'h1c, 32'h0);
        check_word(rd, 32'h0);
        give_verdict;
    end
    initial begin
        repeat (90000) @(posedge clk_sys);
        failures++;
        give_verdict;
    end
endmodule : icc_ctrl_test

// File: test/icc_mem_model.sv
// memory partner: answers fills and takes stored sets, variable latency
`timescale 1ns/1ps
module icc_mem_model (
    input  wire logic        clk_sys,  // clock
    input  wire logic        sys_rst,  // reset
    input  wire logic        mem_req,  // request
    input  wire logic        mem_we,   // write
    input  wire logic [31:0] mem_addr, // byte address
    input  wire logic [1:0]  lat,      // extra wait cycles
    output logic             mem_ack,  // done pulse
    output logic [31:0]      mem_rdata // read data
);
    logic [1:0] wait_reg;
    logic       cool_reg;
    always_ff @(posedge clk_sys) begin
        mem_ack <= 1'b0;
        // data toggles off the ack so stale words never pass as fresh
        mem_rdata <= ~mem_rdata;
        if (sys_rst) begin
            wait_reg <= 2'h0;
            cool_reg <= 1'b0;
            mem_rdata <= 32'h5a5a_0ff0;
        end else if (mem_ack || cool_reg) begin
            cool_reg <= mem_ack;
            wait_reg <= lat;
        end else if (mem_req && wait_reg != 2'h0) begin
            wait_reg <= wait_reg - 2'h1;
        end else if (mem_req) begin
            mem_ack <= 1'b1;
            if (!mem_we)
                mem_rdata <= mem_addr ^ 32'hc3c3_3c3c;
        end
    end
endmodule : icc_mem_model
